/* File: watchdog_params.svh */
// Offsets, field positions, reset values and timing counts of the watchdog block.
// Assumes nothing; included by the package user files by bare name.
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

`define WDT_SERVICE_IDX    8'hA6
`define WDT_PROGRAM_IDX    8'hA7
`define WDT_MODE_IDX       8'hA8
`define WDT_STATUS_IDX     8'hA9
`define WDT_ADDR_W         10
`define WDT_KEY_FIRST      8'h1E
`define WDT_KEY_SECOND     8'hE1
`define WDT_SEL_W          3
`define WDT_SEL_RESET      3'h0
`define WDT_BASE_BITS      14
`define WDT_CNT_W          21
`define WDT_MODE_IDLE_BIT  0
`define WDT_MODE_PD_BIT    1
`define WDT_MODE_WAKE_BIT  2
`define WDT_MODE_ACK_BIT   3
`define WDT_CLKS_PER_MC    12
`define WDT_RST_OUT_CLKS   96
`define WDT_RST_IN_MC      2
`define WDT_START_ADDR     16'h0000

`endif

/* File: watchdog_pkg.sv */
// Types shared by the watchdog block, its checker and the bench.
// Assumes the parameter header is on the include path.
package watchdog_pkg;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_POWER_DOWN,
    MODE_WAKE_HOLD
  } power_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

/* File: watchdog_counter.sv */
// Watchdog counter with programmable length of 2**(14+n)-1 machine cycles.
// Assumes count enables are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_params.svh"

module watchdog_counter #(
  parameter int CNT_W = `WDT_CNT_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic                  clear,
  input  wire logic                  step,
  input  wire logic [`WDT_SEL_W-1:0] timeoutSelect,
  output logic                       overflow
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] limit;
  logic             overflow_d;
  logic             overflow_q;

  // Each select step doubles the base length.
  always_comb begin
    limit      = CNT_W'((64'd1 << (`WDT_BASE_BITS + timeoutSelect)) - 64'd1);
    count_d    = count_q;
    overflow_d = 1'b0;
    if (clear) begin
      count_d = '0;
    end else if (step) begin
      // Overflow as the count reaches the limit; >= also catches a count left above a newly shortened limit.
      if (count_q >= limit - CNT_W'(1)) begin
        overflow_d = 1'b1;
        count_d    = '0;
      end else begin
        count_d = count_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_q    <= '0;
      overflow_q <= 1'b0;
    end else begin
      count_q    <= count_d;
      overflow_q <= overflow_d;
    end
  end

  assign overflow = overflow_q;

endmodule
`default_nettype wire

/* File: watchdog_with_power_modes.sv */
// Hardware watchdog with power-down and idle handling, warm reset and reset-pin pulse, APB slave.
// Assumes ref_clk is the peripheral clock, srst the power-on reset, and pins arrive asynchronously.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_params.svh"

module watchdog_with_power_modes #(
  parameter int CLKS_PER_MC = `WDT_CLKS_PER_MC,
  parameter int RST_OUT_CLKS = `WDT_RST_OUT_CLKS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire watchdog_pkg::apb_req_t apbReq,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rstPinIn,
  output logic                       rstPinOut,
  output logic                       rstPinOe,
  input  wire logic                  extIntInN,
  output logic                       coreReset,
  output logic [15:0]                coreStartAddr,
  output logic                       oscRunning,
  output logic                       cpuIdle
);
  import watchdog_pkg::*;

  localparam int MC_W = $clog2(CLKS_PER_MC);
  localparam int PULSE_W = $clog2(RST_OUT_CLKS + 1);
  localparam int PIN_CLKS = `WDT_RST_IN_MC * CLKS_PER_MC;
  localparam int PIN_W = $clog2(PIN_CLKS + 1);

  // Pin synchronisers; only the second stage is read.
  logic rstMeta_q;
  logic rstSync_q;
  logic intMeta_q;
  logic intSync_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
      intMeta_q <= 1'b1;
      intSync_q <= 1'b1;
    end else begin
      rstMeta_q <= rstPinIn;
      rstSync_q <= rstMeta_q;
      intMeta_q <= extIntInN;
      intSync_q <= intMeta_q;
    end
  end

  // Control and status state.
  power_mode_t             mode_q, mode_d;
  logic [MC_W-1:0]         mcCnt_q, mcCnt_d;
  logic [PULSE_W-1:0]      pulseCnt_q, pulseCnt_d;
  logic [PIN_W-1:0]        pinCnt_q, pinCnt_d;
  logic                    enabled_q, enabled_d;
  logic                    keyArmed_q, keyArmed_d;
  logic [`WDT_SEL_W-1:0]   sel_q, sel_d;
  logic                    wakeEn_q, wakeEn_d;
  logic                    wdtCause_q, wdtCause_d;
  logic                    coreReset_q, coreReset_d;
  logic                    pready_q, pready_d;
  logic                    pslverr_q, pslverr_d;
  logic [31:0]             prdata_q, prdata_d;
  logic                    mcStep;
  logic                    restart;
  logic                    overflow;
  logic                    pinValid;
  logic                    warm;
  logic                    wrDone;
  logic [7:0]              wIdx;
  logic                    wLow;

  assign wIdx     = apbReq.paddr[`WDT_ADDR_W-1:2];
  assign wLow     = apbReq.paddr[1:0] == 2'b00 && apbReq.paddr[11:`WDT_ADDR_W] == '0;
  assign wrDone   = apbReq.psel && apbReq.penable && pready_q && apbReq.pwrite;
  assign pinValid = pinCnt_q == PIN_W'(PIN_CLKS);
  assign warm     = pinValid || pulseCnt_q != '0 || overflow;

  // The oscillator is off in power-down, so the machine-cycle divider and the watchdog count hold.
  assign mcStep = (mcCnt_q == MC_W'(CLKS_PER_MC - 1)) && mode_q != MODE_POWER_DOWN;

  watchdog_counter u_counter (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .clear         (restart || !enabled_q || warm),
    // Idle still counts; a wake hold does not.
    .step          (mcStep && enabled_q && mode_q != MODE_WAKE_HOLD),
    .timeoutSelect (sel_q),
    .overflow      (overflow)
  );

  always_comb begin
    mode_d      = mode_q;
    mcCnt_d     = mode_q == MODE_POWER_DOWN ? mcCnt_q :
                  (mcStep ? '0 : mcCnt_q + MC_W'(1));
    pulseCnt_d  = pulseCnt_q;
    pinCnt_d    = rstSync_q ? (pinValid ? pinCnt_q : pinCnt_q + PIN_W'(1)) : '0;
    enabled_d   = enabled_q;
    keyArmed_d  = keyArmed_q;
    sel_d       = sel_q;
    wakeEn_d    = wakeEn_q;
    wdtCause_d  = wdtCause_q;
    restart     = 1'b0;
    pready_d    = apbReq.psel && apbReq.penable && !pready_q;
    pslverr_d   = 1'b0;
    prdata_d    = prdata_q;
    if (apbReq.psel && apbReq.penable && !pready_q) begin
      prdata_d  = '0;
      pslverr_d = !(wLow && (wIdx == `WDT_SERVICE_IDX || wIdx == `WDT_PROGRAM_IDX ||
                   wIdx == `WDT_MODE_IDX || wIdx == `WDT_STATUS_IDX));
      if (wLow && wIdx == `WDT_PROGRAM_IDX) begin
        prdata_d[`WDT_SEL_W-1:0] = sel_q;
      end
      if (wLow && wIdx == `WDT_MODE_IDX) begin
        prdata_d[`WDT_MODE_WAKE_BIT] = wakeEn_q;
      end
      if (wLow && wIdx == `WDT_STATUS_IDX) begin
        prdata_d[5:0] = {mode_q, intSync_q, keyArmed_q, wdtCause_q, enabled_q};
      end
    end
    if (wrDone && wLow && wIdx == `WDT_SERVICE_IDX) begin
      keyArmed_d = apbReq.pwdata[7:0] == `WDT_KEY_FIRST;
      if (keyArmed_q && apbReq.pwdata[7:0] == `WDT_KEY_SECOND) begin
        enabled_d = 1'b1;
        restart   = 1'b1;
      end
    end
    if (wrDone && wLow && wIdx == `WDT_PROGRAM_IDX) begin
      sel_d = apbReq.pwdata[`WDT_SEL_W-1:0];
    end
    if (wrDone && wLow && wIdx == `WDT_STATUS_IDX && apbReq.pwdata[1]) begin
      wdtCause_d = 1'b0;
    end
    if (wrDone && wLow && wIdx == `WDT_MODE_IDX) begin
      wakeEn_d = apbReq.pwdata[`WDT_MODE_WAKE_BIT];
      if (apbReq.pwdata[`WDT_MODE_PD_BIT]) begin
        mode_d = MODE_POWER_DOWN;
      end else if (apbReq.pwdata[`WDT_MODE_IDLE_BIT]) begin
        mode_d = MODE_IDLE;
      end
    end
    unique case (mode_q)
      MODE_RUN: begin
      end
      MODE_IDLE: begin
        if (!intSync_q && wakeEn_q) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_POWER_DOWN: begin
        if (!intSync_q && wakeEn_q) begin
          mode_d = MODE_WAKE_HOLD;
        end
      end
      MODE_WAKE_HOLD: begin
        // Service is signalled by the handler writing the acknowledge bit.
        if (intSync_q && wrDone && wLow && wIdx == `WDT_MODE_IDX && apbReq.pwdata[`WDT_MODE_ACK_BIT]) begin
          mode_d = MODE_RUN;
        end
      end
    endcase
    if (overflow) begin
      pulseCnt_d = PULSE_W'(RST_OUT_CLKS);
    end else if (pulseCnt_q != '0) begin
      pulseCnt_d = pulseCnt_q - PULSE_W'(1);
    end
    // The cause flag set wins over a software clear in the same cycle.
    if (overflow) begin
      wdtCause_d = 1'b1;
    end
    // Warm reset reinitialises everything software sees except the cause flag.
    if (warm) begin
      mode_d     = MODE_RUN;
      enabled_d  = 1'b0;
      keyArmed_d = 1'b0;
      sel_d      = `WDT_SEL_RESET;
      wakeEn_d   = 1'b0;
    end
    coreReset_d = warm;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_q      <= MODE_RUN;
      mcCnt_q     <= '0;
      pulseCnt_q  <= '0;
      pinCnt_q    <= '0;
      enabled_q   <= 1'b0;
      keyArmed_q  <= 1'b0;
      sel_q       <= `WDT_SEL_RESET;
      wakeEn_q    <= 1'b0;
      wdtCause_q  <= 1'b0;
      coreReset_q <= 1'b1;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= '0;
    end else begin
      mode_q      <= mode_d;
      mcCnt_q     <= mcCnt_d;
      pulseCnt_q  <= pulseCnt_d;
      pinCnt_q    <= pinCnt_d;
      enabled_q   <= enabled_d;
      keyArmed_q  <= keyArmed_d;
      sel_q       <= sel_d;
      wakeEn_q    <= wakeEn_d;
      wdtCause_q  <= wdtCause_d;
      coreReset_q <= coreReset_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      prdata_q    <= prdata_d;
    end
  end

  // Registered pin drive; the pulse also reads back through the pin, lengthening reset slightly.
  logic rstOe_q;
  logic osc_q;
  logic idle_q;
  logic [15:0] startAddr_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rstOe_q     <= 1'b0;
      osc_q       <= 1'b1;
      idle_q      <= 1'b0;
      startAddr_q <= `WDT_START_ADDR;
    end else begin
      rstOe_q     <= pulseCnt_d != '0;
      osc_q       <= mode_d != MODE_POWER_DOWN;
      idle_q      <= mode_d == MODE_IDLE;
      startAddr_q <= `WDT_START_ADDR;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign rstPinOut     = rstOe_q;
  assign rstPinOe      = rstOe_q;
  assign coreReset     = coreReset_q;
  assign coreStartAddr = startAddr_q;
  assign oscRunning    = osc_q;
  assign cpuIdle       = idle_q;

endmodule
`default_nettype wire

/* File: watchdog_chk_asserts.sv */
// Port checker for the watchdog block.
// Assumes it is bound to watchdog_with_power_modes.
`timescale 1ns/1ps
`default_nettype none
module watchdog_chk_asserts import watchdog_pkg::*; #(
  parameter int CLKS_PER_MC  = 12,
  parameter int RST_OUT_CLKS = 96
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire apb_req_t    apbReq,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rstPinIn,
  input wire logic        rstPinOut,
  input wire logic        rstPinOe,
  input wire logic        coreReset,
  input wire logic [15:0] coreStartAddr,
  input wire logic        oscRunning,
  input wire logic        cpuIdle
);
  logic [7:0] oeCnt_q, oeCnt_d, pinCnt_q, pinCnt_d;
  // The pin counter saturates so a long reset never wraps back into the antecedent.
  always_comb begin
    oeCnt_d = rstPinOe ? oeCnt_q + 8'h01 : 8'h00;
    pinCnt_d = !rstPinIn ? 8'h00 : (pinCnt_q < 8'h28 ? pinCnt_q + 8'h01 : pinCnt_q);
  end
  always_ff @(posedge ref_clk) begin
    oeCnt_q <= srst ? 8'h00 : oeCnt_d;
    pinCnt_q <= srst ? 8'h00 : pinCnt_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_access;
    apbReq.psel && apbReq.penable && !pready;
  endsequence
  property p_ready; s_access |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("Access not answered in one cycle.");
  property p_errReady; pslverr |-> pready; endproperty
  a_errReady: assert property (p_errReady) else $error("Error without ready.");
  property p_addr; coreStartAddr == 16'h0000; endproperty
  a_addr: assert property (p_addr) else $error("Start address not zero.");
  property p_release; $fell(srst) |-> ##[1:3] !coreReset; endproperty
  a_release: assert property (p_release) else $error("Core reset stuck.");
  property p_oeLen; $fell(rstPinOe) |-> oeCnt_q == RST_OUT_CLKS; endproperty
  a_oeLen: assert property (p_oeLen) else $error("Pin pulse length wrong.");
  property p_oeCore; $rose(rstPinOe) |-> coreReset && rstPinOut; endproperty
  a_oeCore: assert property (p_oeCore) else $error("Pulse without core reset.");
  property p_pdFrozen; !oscRunning |-> !$rose(rstPinOe); endproperty
  a_pdFrozen: assert property (p_pdFrozen) else $error("Overflow in power-down.");
  property p_idleRun; cpuIdle |-> oscRunning; endproperty
  a_idleRun: assert property (p_idleRun) else $error("Oscillator off in idle.");
  property p_pinRst; pinCnt_q == 8'h20 |-> coreReset; endproperty
  a_pinRst: assert property (p_pinRst) else $error("Pin reset not taken.");
endmodule
bind watchdog_with_power_modes watchdog_chk_asserts #(
  .CLKS_PER_MC(CLKS_PER_MC), .RST_OUT_CLKS(RST_OUT_CLKS)
) chk_u (.ref_clk, .srst, .apbReq, .pready, .pslverr, .rstPinIn, .rstPinOut, .rstPinOe,
  .coreReset, .coreStartAddr, .oscRunning, .cpuIdle);
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the watchdog block.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import watchdog_pkg::*;
  logic        ref_clk, srst, rstPinIn, extIntInN, pready, pslverr, er;
  logic        rstPinOut, rstPinOe, coreReset, oscRunning, cpuIdle;
  apb_req_t    apbReq;
  logic [31:0] prdata, rd;
  logic [15:0] coreStartAddr;
  int          num_errors, checked, cyc, t0, n;
  localparam logic [11:0] SVC = 12'h298, PRG = 12'h29C, MODE = 12'h2A0, STAT = 12'h2A4;
  // A short machine cycle keeps the longer time-out inside the run.
  watchdog_with_power_modes #(.CLKS_PER_MC(2), .RST_OUT_CLKS(8)) dut_u (.ref_clk, .srst, .apbReq,
    .prdata, .pready, .pslverr, .rstPinIn, .rstPinOut, .rstPinOe, .extIntInN, .coreReset,
    .coreStartAddr, .oscRunning, .cpuIdle);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apbReq <= '0;
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    srst = 1'b1;
    apbReq = '0;
    rstPinIn = 1'b0;
    extIntInN = 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("coreReset", 1, coreReset);
    srst <= 1'b0;
    apb(0, PRG, 0);
    chk("prgReset", 0, rd);
    apb(1, PRG, 32'hFF);
    apb(0, PRG, 0);
    chk("prgUpper", 32'h7, rd);
    apb(0, SVC, 0);
    chk("svcRead", 0, rd);
    apb(0, 12'hFFC, 0);
    chk("unmapped", 1, er);
    apb(1, SVC, 32'h1E);
    apb(1, SVC, 32'hE1);
    apb(0, STAT, 0);
    chk("enabled", 1, rd[0]);
    $display("test registers done");
    apb(1, MODE, 32'h4);
    apb(1, SVC, 32'h1E);
    apb(1, SVC, 32'hE1);
    // The wake enable bit is rewritten by every mode write, so it goes along with the power-down bit.
    apb(1, MODE, 32'h6);
    repeat (3) @(posedge ref_clk);
    chk("oscOff", 0, oscRunning);
    extIntInN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    apb(0, STAT, 0);
    chk("wakeHold", 3, rd[5:4]);
    chk("oscOn", 1, oscRunning);
    extIntInN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1, MODE, 32'h8);
    apb(0, STAT, 0);
    chk("runAgain", 0, rd[5:4]);
    apb(1, SVC, 32'h1E);
    apb(1, SVC, 32'hE1);
    $display("test power-down done");
    apb(1, PRG, 32'h1);
    apb(1, MODE, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("idle", 1, cpuIdle);
    apb(1, SVC, 32'h1E);
    apb(1, SVC, 32'hE1);
    t0 = cyc;
    while (rstPinOe !== 1'b1) @(posedge ref_clk);
    chk("ovfTime", 1, (cyc - t0 >= 65530) && (cyc - t0 <= 65550));
    chk("warmRst", 1, coreReset);
    n = 0;
    while (rstPinOe === 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
    chk("oeLen", 8, n);
    while (coreReset !== 1'b0) @(posedge ref_clk);
    apb(0, STAT, 0);
    chk("cause", 32'h2, rd & 32'h3);
    apb(0, PRG, 0);
    chk("prgWarm", 0, rd);
    apb(1, STAT, 32'h2);
    apb(0, STAT, 0);
    chk("causeClr", 0, rd[1]);
    apb(1, MODE, 32'h5);
    extIntInN <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("idleExit", 0, cpuIdle);
    extIntInN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("test overflow done");
    apb(1, MODE, 32'h2);
    rstPinIn <= 1'b1;
    repeat (34) @(posedge ref_clk);
    chk("pinRst", 1, coreReset);
    rstPinIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("startAddr", 0, coreStartAddr);
    while (coreReset !== 1'b0) @(posedge ref_clk);
    apb(0, STAT, 0);
    chk("pinExit", 0, rd[5:4]);
    chk("pinDisable", 0, rd[0]);
    apb(1, SVC, 32'h1E);
    apb(1, SVC, 32'hE1);
    apb(0, STAT, 0);
    chk("pinService", 1, rd[0]);
    $display("test pin reset done");
    results();
  end
endmodule
`default_nettype wire
